/* File: verilog/qdm_defect_monitor.sv */
`timescale 1ns/1ps
module qdm_defect_monitor
	import qdm_pkg::*;
#(
	parameter int TICK_DIV = TICK_DIV_DEF
) (
	input  wire logic                                clk,
	input  wire logic                                reset_n,
	input  wire logic [NUM_CARRIERS-1:0]             carrierUsed,
	input  wire logic [NUM_CARRIERS-1:0]             sampleValid,
	input  wire logic [NUM_CARRIERS-1:0][PWR_W-1:0]  powerSample,
	input  wire qdm_power_t                          powerThreshold,
	input  wire qdm_report_t                         farReport,
	input  wire logic                                ocdAnomaly,
	input  wire logic                                focdAnomaly,
	input  wire logic                                fncdAnomaly,
	input  wire logic                                rdiDefect,
	input  wire logic                                perAnomaly,
	input  wire logic                                cfgLoad,
	input  wire qdm_timers_t                         cfgTimers,
	output logic [NUM_CARRIERS-1:0]                  carrierAbsentDefect,
	output logic                                     signalAbsentDefect,
	output logic [NUM_CARRIERS-1:0]                  farCarrierAbsentDefect,
	output logic                                     farSignalAbsentDefect,
	output logic                                     cellDelinMissingDefect,
	output logic                                     farDelinMissingDefect,
	output logic                                     packetErrorDefect,
	output qdm_timers_t                              failureTimers
);

	logic [DIV_W-1:0]   divCnt_r;
	logic               tick_r;
	qdm_ms_t            winCnt_r;
	logic               winEnd;
	logic [SUM_W-1:0]   sum_r   [NUM_CARRIERS];
	qdm_power_t         count_r [NUM_CARRIERS];
	logic [SUM_W-1:0]   limit   [NUM_CARRIERS];
	logic [FAR_WIN-1:0] hist_r  [NUM_CARRIERS];
	logic [2:0]         ones    [NUM_CARRIERS];
	logic [2:0]         fill_r;
	logic               fncdLong;
	logic               farQuiet;

	function automatic logic [2:0] countOnes(input logic [FAR_WIN-1:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < FAR_WIN; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

	// Timebase divider: one-cycle tick per millisecond
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_r <= '0;
			tick_r   <= 1'b0;
		end else if (divCnt_r == DIV_W'(TICK_DIV - 1)) begin
			divCnt_r <= '0;
			tick_r   <= 1'b1;
		end else begin
			divCnt_r <= divCnt_r + 1'b1;
			tick_r   <= 1'b0;
		end
	end

	// Half-second averaging window shared by both carriers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			winCnt_r <= CNT_ZERO;
		end else if (winEnd) begin
			winCnt_r <= CNT_ZERO;
		end else if (tick_r) begin
			winCnt_r <= winCnt_r + CNT_ONE;
		end
	end

	assign winEnd = tick_r && (winCnt_r == AVG_WIN_TICKS - CNT_ONE);

	// Average compared as sum against threshold times sample count, no divider needed
	for (genvar c = 0; c < NUM_CARRIERS; c++) begin : g_carrier
		assign limit[c] = SUM_W'(powerThreshold) * SUM_W'(count_r[c]);
		assign ones[c]  = countOnes(hist_r[c]);

		// Power accumulation; count saturates so a very fast sampler cannot wrap
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				sum_r[c]   <= SUM_ZERO;
				count_r[c] <= '0;
			end else if (winEnd) begin
				sum_r[c]   <= SUM_ZERO;
				count_r[c] <= '0;
			end else if (sampleValid[c] && count_r[c] != PWR_MAX) begin
				sum_r[c]   <= sum_r[c] + {{(SUM_W-PWR_W){1'b0}}, powerSample[c]};
				count_r[c] <= count_r[c] + PWR_ONE;
			end
		end

		// Decision at window end; an empty window keeps the last verdict
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				carrierAbsentDefect[c] <= 1'b0;
			end else if (winEnd && count_r[c] != '0) begin
				carrierAbsentDefect[c] <= (sum_r[c] < limit[c]);
			end
		end

		// Shift history of far absence flags
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				hist_r[c] <= '0;
			end else if (farReport.valid) begin
				hist_r[c] <= {hist_r[c][FAR_WIN-2:0], farReport.carrierAbsent[c]};
			end
		end

		// Far absence verdict only once six reports are in
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				farCarrierAbsentDefect[c] <= 1'b0;
			end else if (fill_r == FAR_FULL) begin
				if (ones[c] >= FAR_SET) begin
					farCarrierAbsentDefect[c] <= 1'b1;
				end else if (ones[c] < FAR_CLR) begin
					farCarrierAbsentDefect[c] <= 1'b0;
				end
			end
		end

		property p_far_rise;
			@(posedge clk) disable iff (!reset_n)
			$rose(farCarrierAbsentDefect[c]) |-> $past(ones[c]) >= FAR_SET;
		endproperty
		a_far_rise: assert property (p_far_rise) else $error("far absence raised below four");

		property p_far_fall;
			@(posedge clk) disable iff (!reset_n)
			$fell(farCarrierAbsentDefect[c]) |-> $past(ones[c]) < FAR_CLR;
		endproperty
		a_far_fall: assert property (p_far_fall) else $error("far absence cleared at two or more");

		property p_hist_shift;
			@(posedge clk) disable iff (!reset_n)
			farReport.valid |=> hist_r[c][0] == $past(farReport.carrierAbsent[c]);
		endproperty
		a_hist_shift: assert property (p_hist_shift) else $error("history not shifted");

		property p_carrier_low;
			@(posedge clk) disable iff (!reset_n)
			(winEnd && count_r[c] != '0 && sum_r[c] < limit[c]) |=> carrierAbsentDefect[c];
		endproperty
		a_carrier_low: assert property (p_carrier_low) else $error("low power not flagged");

		property p_carrier_ok;
			@(posedge clk) disable iff (!reset_n)
			(winEnd && count_r[c] != '0 && sum_r[c] >= limit[c]) |=> !carrierAbsentDefect[c];
		endproperty
		a_carrier_ok: assert property (p_carrier_ok) else $error("adequate power still flagged");
	end

	// Reports received, saturating at the history depth
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fill_r <= 3'h0;
		end else if (farReport.valid && fill_r != FAR_FULL) begin
			fill_r <= fill_r + 3'h1;
		end
	end

	// Line-level aggregation: raise on any profile carrier, clear only when both are free
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			signalAbsentDefect    <= 1'b0;
			farSignalAbsentDefect <= 1'b0;
		end else begin
			if (|(carrierAbsentDefect & carrierUsed)) begin
				signalAbsentDefect <= 1'b1;
			end else if (carrierAbsentDefect == '0) begin
				signalAbsentDefect <= 1'b0;
			end
			if (|(farCarrierAbsentDefect & carrierUsed)) begin
				farSignalAbsentDefect <= 1'b1;
			end else if (farCarrierAbsentDefect == '0) begin
				farSignalAbsentDefect <= 1'b0;
			end
		end
	end

	// Near-end cell delineation loss
	qdm_persist #(.ONSET(LCD_ONSET_TICKS), .CLEAR(LCD_CLEAR_TICKS)) u_lcd (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick_r),
		.cond    (ocdAnomaly),
		.defect  (cellDelinMissingDefect)
	);

	// Far ncd held beyond 50 ms; drops on the first tick it is gone
	qdm_persist #(.ONSET(LCD_ONSET_TICKS), .CLEAR(CNT_ONE)) u_fncd (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick_r),
		.cond    (fncdAnomaly),
		.defect  (fncdLong)
	);

	// Both far anomalies absent for more than 50 ms
	qdm_persist #(.ONSET(LCD_ONSET_TICKS), .CLEAR(CNT_ONE)) u_fquiet (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick_r),
		.cond    (!(focdAnomaly || fncdAnomaly)),
		.defect  (farQuiet)
	);

	// Far delineation loss; onset wins over a stale quiet verdict
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			farDelinMissingDefect <= 1'b0;
		end else if (!rdiDefect && (focdAnomaly || fncdLong)) begin
			farDelinMissingDefect <= 1'b1;
		end else if (farQuiet) begin
			farDelinMissingDefect <= 1'b0;
		end
	end

	// Packet error defect
	qdm_persist #(.ONSET(PER_TICKS), .CLEAR(PER_TICKS)) u_per (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick_r),
		.cond    (perAnomaly),
		.defect  (packetErrorDefect)
	);

	// Failure timer durations, defaults at reset, software may reload
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			failureTimers <= TIMERS_DEF;
		end else if (cfgLoad) begin
			failureTimers <= cfgTimers;
		end
	end

	property p_sig_raise;
		@(posedge clk) disable iff (!reset_n)
		|(carrierAbsentDefect & carrierUsed) |=> signalAbsentDefect;
	endproperty
	a_sig_raise: assert property (p_sig_raise) else $error("signal absence not raised");

	property p_sig_hold;
		@(posedge clk) disable iff (!reset_n)
		(signalAbsentDefect && carrierAbsentDefect != '0) |=> signalAbsentDefect;
	endproperty
	a_sig_hold: assert property (p_sig_hold) else $error("signal absence cleared early");

	property p_fsig;
		@(posedge clk) disable iff (!reset_n)
		$fell(farSignalAbsentDefect) |-> $past(farCarrierAbsentDefect) == '0;
	endproperty
	a_fsig: assert property (p_fsig) else $error("far signal absence cleared early");

	property p_flcd_rise;
		@(posedge clk) disable iff (!reset_n)
		$rose(farDelinMissingDefect) |-> $past(!rdiDefect && (focdAnomaly || fncdLong));
	endproperty
	a_flcd_rise: assert property (p_flcd_rise) else $error("far delineation loss without cause");

	property p_flcd_fall;
		@(posedge clk) disable iff (!reset_n)
		$fell(farDelinMissingDefect) |-> $past(farQuiet);
	endproperty
	a_flcd_fall: assert property (p_flcd_fall) else $error("far delineation loss cleared early");

	property p_timers_hold;
		@(posedge clk) disable iff (!reset_n)
		!$past(cfgLoad) |-> $stable(failureTimers);
	endproperty
	a_timers_hold: assert property (p_timers_hold) else $error("timers changed without load");

endmodule

/* File: shared/qdm_pkg.sv */
package qdm_pkg;

	// Clock and timebase
	localparam int CLK_HZ       = 40_000_000;
	localparam int TICK_US      = 1000;
	localparam int TICK_DIV_DEF = CLK_HZ / (1_000_000 / TICK_US);
	localparam int DIV_W        = 16;

	// Persistence counters count timebase ticks
	localparam int CNT_W = 13;
	typedef logic [CNT_W-1:0] qdm_ms_t;
	localparam qdm_ms_t CNT_ZERO = 13'h0;
	localparam qdm_ms_t CNT_ONE  = 13'h1;

	// Carriers and power measurement
	localparam int NUM_CARRIERS = 2;
	localparam int PWR_W        = 16;
	localparam int SUM_W        = 32;
	typedef logic [PWR_W-1:0] qdm_power_t;
	localparam logic [SUM_W-1:0] SUM_ZERO = 32'h0;
	localparam qdm_power_t       PWR_ONE  = 16'h1;
	localparam qdm_power_t       PWR_MAX  = 16'hffff;

	// Averaging window for carrier power
	localparam int      AVG_WIN_MS    = 500;
	localparam qdm_ms_t AVG_WIN_TICKS = CNT_W'(AVG_WIN_MS * 1000 / TICK_US);

	// Far-end report history
	localparam int         FAR_WIN = 6;
	localparam logic [2:0] FAR_SET = 3'h4;
	localparam logic [2:0] FAR_CLR = 3'h2;
	localparam logic [2:0] FAR_FULL = 3'h6;

	// Delineation persistence: onset is strictly more than, clear is at least
	localparam int      LCD_TIME_MS     = 50;
	localparam qdm_ms_t LCD_ONSET_TICKS = CNT_W'(LCD_TIME_MS * 1000 / TICK_US + 1);
	localparam qdm_ms_t LCD_CLEAR_TICKS = CNT_W'(LCD_TIME_MS * 1000 / TICK_US);

	// Packet error persistence, strictly more than both ways
	localparam int      PER_TIME_MS = 500;
	localparam qdm_ms_t PER_TICKS   = CNT_W'(PER_TIME_MS * 1000 / TICK_US + 1);

	// Failure timer defaults in milliseconds
	localparam qdm_ms_t FAIL_DEF_MS   = 13'h1f4;
	localparam qdm_ms_t POWER1_DEF_MS = 13'h9c4;
	localparam qdm_ms_t POWER2_DEF_MS = 13'h1388;

	typedef struct packed {
		qdm_ms_t a1;
		qdm_ms_t a2;
		qdm_ms_t b1;
		qdm_ms_t b2;
		qdm_ms_t c1;
		qdm_ms_t c2;
		qdm_ms_t p1;
		qdm_ms_t p2;
	} qdm_timers_t;

	localparam qdm_timers_t TIMERS_DEF = '{
		a1: FAIL_DEF_MS, a2: FAIL_DEF_MS, b1: FAIL_DEF_MS, b2: FAIL_DEF_MS,
		c1: FAIL_DEF_MS, c2: FAIL_DEF_MS, p1: POWER1_DEF_MS, p2: POWER2_DEF_MS
	};

	// Far-end indicator report
	typedef struct packed {
		logic                    valid;
		logic [NUM_CARRIERS-1:0] carrierAbsent;
	} qdm_report_t;

endpackage

/* File: verilog/qdm_persist.sv */
`timescale 1ns/1ps
module qdm_persist
	import qdm_pkg::*;
#(
	parameter qdm_ms_t ONSET = CNT_ONE,
	parameter qdm_ms_t CLEAR = CNT_ONE
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic tick,
	input  wire logic cond,
	output logic      defect
);

	qdm_ms_t cnt_r;
	qdm_ms_t limit;

	assign limit = defect ? CLEAR : ONSET;

	// Count ticks while the condition disagrees with the defect state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r  <= CNT_ZERO;
			defect <= 1'b0;
		end else if (cond == defect) begin
			cnt_r <= CNT_ZERO;
		end else if (tick) begin
			if (cnt_r + CNT_ONE >= limit) begin
				cnt_r  <= CNT_ZERO;
				defect <= cond;
			end else begin
				cnt_r <= cnt_r + CNT_ONE;
			end
		end
	end

	property p_persist_restart;
		@(posedge clk) disable iff (!reset_n)
		(cond == defect) |=> (cnt_r == CNT_ZERO);
	endproperty
	a_persist_restart: assert property (p_persist_restart) else $error("persist counter not restarted");

	property p_persist_onset;
		@(posedge clk) disable iff (!reset_n)
		$rose(defect) |-> $past(tick) && $past(cond) && ($past(cnt_r) == ONSET - CNT_ONE);
	endproperty
	a_persist_onset: assert property (p_persist_onset) else $error("defect raised at wrong count");

	property p_persist_clear;
		@(posedge clk) disable iff (!reset_n)
		$fell(defect) |-> $past(tick) && !$past(cond) && ($past(cnt_r) == CLEAR - CNT_ONE);
	endproperty
	a_persist_clear: assert property (p_persist_clear) else $error("defect cleared at wrong count");

endmodule

/* File: tb/qdm_far_model.sv */
`timescale 1ns/1ps
module qdm_far_model
	import qdm_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    sendReq,
	input  wire logic [NUM_CARRIERS-1:0] absentIn,
	output qdm_report_t                  farReport
);
	// One report per request, spacing set by the bench (prompt or slow)
	// Between reports the flags toggle, so a stale value is never mistaken for data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			farReport <= '0;
		end else if (sendReq) begin
			farReport <= {1'b1, absentIn};
		end else begin
			farReport <= {1'b0, ~farReport.carrierAbsent};
		end
	end
endmodule

/* File: tb/test_qdm_defect_monitor.sv */
`timescale 1ns/1ps
module test_qdm_defect_monitor import qdm_pkg::*;;
	logic             clk = 1'b0;
	logic             reset_n = 1'b0;
	logic [1:0]       used = 2'h0;
	logic [1:0]       sv = 2'h0;
	logic [1:0]       farAbs = 2'h0;
	logic [1:0][15:0] pwr = '0;
	qdm_power_t       thr = 16'h0100;
	logic             ocd = 1'b0;
	logic             focd = 1'b0;
	logic             fncd = 1'b0;
	logic             rdi = 1'b0;
	logic             per = 1'b0;
	logic             cfgLoad = 1'b0;
	logic             sendReq = 1'b0;
	qdm_timers_t      cfgT = TIMERS_DEF;
	qdm_report_t      farRep;
	logic [1:0]       cad;
	logic [1:0]       fcad;
	logic             sad;
	logic             fsad;
	logic             lcd;
	logic             flcd;
	logic             pe;
	qdm_timers_t      tim;
	int               failCount = 0;
	int               checked = 0;
	int               cycles = 0;

	// Clock, 25 ns period
	always #12.5 clk = ~clk;

	// Four cycles per timebase tick keeps every window short
	qdm_defect_monitor #(.TICK_DIV(4)) dut (.clk(clk), .reset_n(reset_n), .carrierUsed(used),
		.sampleValid(sv), .powerSample(pwr), .powerThreshold(thr), .farReport(farRep),
		.ocdAnomaly(ocd), .focdAnomaly(focd), .fncdAnomaly(fncd), .rdiDefect(rdi),
		.perAnomaly(per), .cfgLoad(cfgLoad), .cfgTimers(cfgT), .carrierAbsentDefect(cad),
		.signalAbsentDefect(sad), .farCarrierAbsentDefect(fcad), .farSignalAbsentDefect(fsad),
		.cellDelinMissingDefect(lcd), .farDelinMissingDefect(flcd), .packetErrorDefect(pe),
		.failureTimers(tim));

	qdm_far_model far (.clk(clk), .reset_n(reset_n), .sendReq(sendReq), .absentIn(farAbs),
		.farReport(farRep));

	// Inputs always move 1 ns after the edge, clear of the sampling instant
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		checked++;
		if (g !== e) begin
			failCount++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkTim(input string nm, input qdm_timers_t e, input qdm_timers_t g);
		checked++;
		if (g !== e) begin
			failCount++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic tReset;
		chk("defects", 9'h0, {cad, fcad, sad, fsad, lcd, flcd, pe});
		chkTim("failureTimers", {{6{13'h01f4}}, 13'h09c4, 13'h1388}, tim);
		cfgT = {8{13'h0abc}};
		cfgLoad = 1'b1;
		cyc(1);
		cfgLoad = 1'b0;
		chkTim("loadedTimers", {8{13'h0abc}}, tim);
		$display("test reset done");
	endtask

	// Brief drop of the anomaly must restart the onset count
	task automatic tLcd;
		ocd = 1'b1;
		cyc(150);
		ocd = 1'b0;
		cyc(1);
		ocd = 1'b1;
		cyc(196);
		chk("cellDelin", 9'h0, lcd);
		cyc(16);
		chk("cellDelin", 9'h1, lcd);
		ocd = 1'b0;
		cyc(192);
		chk("cellDelin", 9'h1, lcd);
		cyc(16);
		chk("cellDelin", 9'h0, lcd);
		$display("test lcd done");
	endtask

	task automatic tFlcd;
		rdi = 1'b1;
		focd = 1'b1;
		cyc(20);
		chk("farDelin", 9'h0, flcd);
		rdi = 1'b0;
		cyc(3);
		chk("farDelin", 9'h1, flcd);
		focd = 1'b0;
		cyc(196);
		chk("farDelin", 9'h1, flcd);
		cyc(16);
		chk("farDelin", 9'h0, flcd);
		fncd = 1'b1;
		cyc(196);
		chk("farDelin", 9'h0, flcd);
		cyc(16);
		chk("farDelin", 9'h1, flcd);
		fncd = 1'b0;
		cyc(212);
		chk("farDelin", 9'h0, flcd);
		$display("test flcd done");
	endtask

	task automatic tPer;
		per = 1'b1;
		cyc(1996);
		chk("packetError", 9'h0, pe);
		cyc(16);
		chk("packetError", 9'h1, pe);
		per = 1'b0;
		cyc(1996);
		chk("packetError", 9'h1, pe);
		cyc(16);
		chk("packetError", 9'h0, pe);
		$display("test per done");
	endtask

	// Two full windows per step, so the last window before each check sees one power level
	task automatic tPower;
		used = 2'h1;
		sv = 2'h3;
		pwr = {16'h0100, 16'h00ff};
		cyc(4010);
		chk("carrierAndSignal", 9'h3, {cad, sad});
		pwr = {16'h00ff, 16'h0100};
		cyc(4010);
		chk("carrierAndSignal", 9'h5, {cad, sad});
		pwr = {2{16'h0100}};
		cyc(4010);
		chk("carrierAndSignal", 9'h0, {cad, sad});
		sv = 2'h0;
		$display("test power done");
	endtask

	// Reference history per carrier, verdict only after six reports
	task automatic tFar;
		logic [1:0][5:0] hist;
		logic [1:0]      e;
		logic [1:0]      a;
		logic            es;
		logic [9:0]      p0;
		logic [9:0]      p1;
		hist = '0;
		// Only carrier 1 in the profile, so carrier 0 alone must hold far signal absence
		used = 2'h2;
		e = 2'h0;
		es = 1'b0;
		p0 = 10'h2d0;
		p1 = 10'h3c0;
		for (int i = 0; i < 10; i++) begin
			a = {p1[9-i], p0[9-i]};
			farAbs = a;
			sendReq = 1'b1;
			cyc(1);
			sendReq = 1'b0;
			cyc(5);
			for (int c = 0; c < 2; c++) begin
				hist[c] = {hist[c][4:0], a[c]};
				if (i >= 5 && $countones(hist[c]) >= 4) begin
					e[c] = 1'b1;
				end else if (i >= 5 && $countones(hist[c]) < 2) begin
					e[c] = 1'b0;
				end
			end
			if (|(e & used)) begin
				es = 1'b1;
			end else if (e == 2'h0) begin
				es = 1'b0;
			end
			chk("farCarrierAndSignal", {e, es}, {fcad, fsad});
		end
		$display("test far done");
	endtask

	// Hang guard, well above the roughly 17400 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			failCount++;
			conclude();
		end
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		reset_n = 1'b1;
		cyc(1);
		tReset();
		tLcd();
		tFlcd();
		tPer();
		tPower();
		tFar();
		conclude();
	end
endmodule
